// *** hw/ccr_consts.svh ***
// Register map, field positions, reset values and timing figures of the clock and reset control.
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses (low twelve address bits are decoded)
// ----------------------------------------------------------------------------
`define CCR_ADDR_CLKCTL   12'h0d4
`define CCR_ADDR_BTCTL    12'h0d8
`define CCR_ADDR_MODE     12'h0dc
`define CCR_ADDR_STATUS   12'h0e0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CCR_CLKCTL_RST    8'h00
`define CCR_BTCTL_RST     8'h00

// ----------------------------------------------------------------------------
// Clock control fields
// ----------------------------------------------------------------------------
`define CCR_WAKE_BIT      7
`define CCR_STOP_HI       6
`define CCR_STOP_LO       5
`define CCR_DIV_HI        4
`define CCR_DIV_LO        3
`define CCR_SIG_HI        2
`define CCR_SIG_LO        0
`define CCR_STOP_CODE     2'b10
`define CCR_STOP_NONE     2'b00
`define CCR_SIG_BAD       3'b101
`define CCR_DIV_16        2'b00
`define CCR_DIV_8         2'b01
`define CCR_DIV_2         2'b10
`define CCR_DIV_1         2'b11

// ----------------------------------------------------------------------------
// Basic timer control fields
// ----------------------------------------------------------------------------
`define CCR_WDT_HI        7
`define CCR_WDT_LO        4
`define CCR_WDT_OFF       4'b1010
`define CCR_STAB_HI       3
`define CCR_STAB_LO       2
`define CCR_BT_CLR_BIT    1

// ----------------------------------------------------------------------------
// Mode register bits and misc figures
// ----------------------------------------------------------------------------
`define CCR_MODE_IDLE_BIT 0
`define CCR_MODE_STOP_BIT 1
`define CCR_RESET_VECTOR  16'h0100
`define CCR_FILT_DEFAULT  8

`endif

// *** hw/ccr_pkg.sv ***
// Types shared by the clock and reset control.
package ccr_pkg;

	typedef enum logic [1:0] {
		CCR_ST_STAB,
		CCR_ST_RUN,
		CCR_ST_IDLE,
		CCR_ST_STOP
	} ccr_state_t;

	typedef logic [1:0] ccr_div_t;

endpackage

// *** hw/ccr_top.sv ***
// Clock divider, power-down, reset sequence and watchdog of the CPU, with an AHB-Lite slave.
//
// Notes on behaviour
// - Divider field 00,01,10,11 gives oscillator /16, /8, /2, /1 CPU clock.
// - Wake bit 0 lets external interrupts release stop; 1 blocks them.
// - Oscillator stop field halts oscillator only on code 10.
// - Signature field resets to 000; value 101 must never be written.
// - After reset: wake enabled, oscillator running, CPU clock oscillator /16.
// - Stop halts oscillator; only reset or filtered external interrupt ends it.
// - Idle gates CPU clock but keeps peripherals and interrupts clocked.
// - Idle ends on reset or any interrupt, restoring CPU clock.
// - Filtered wake interrupt pins are the only stop wake-up sources.
// - Reset input is synchronised to the clock before use.
// - Reset during operation returns every control register to default.
// - All interrupts are disabled during reset.
// - Watchdog is enabled by reset.
// - Ports 0 to 3 are inputs during reset.
// - Program counter loads reset vector 0100 on reset.
// - First fetch waits until the stabilisation interval has elapsed.
// - Basic timer overflow after stabilisation causes system reset unless watchdog disabled.
// - Upper nibble 1010 of basic timer control disables the watchdog.
// - Stop halts CPU and system clock, keeping control register contents; basic timer prescaler and counter clear.
`timescale 1ns/1ps
`include "ccr_consts.svh"

module ccr_top #(
	parameter int FILT_LEN = `CCR_FILT_DEFAULT
) (
	input  wire logic             hclk,         // Oscillator clock.
	input  wire logic             hresetn,      // Asynchronous reset, active low.
	input  wire logic             hsel,         // Slave select.
	input  wire logic [31:0]      haddr,        // Byte address.
	input  wire logic [1:0]       htrans,       // Transfer type.
	input  wire logic             hwrite,       // Write when high.
	input  wire logic [2:0]       hsize,        // Transfer size.
	input  wire logic [31:0]      hwdata,       // Write data.
	input  wire logic             hready,       // Bus ready.
	output logic      [31:0]      hrdata,       // Read data.
	output logic                  hreadyout,    // Slave ready.
	output logic                  hresp,        // Slave response.
	input  wire logic             reset_pin_n,  // Reset input pin, active low.
	input  wire logic [2:0]       wake_interrupt_pins, // External interrupt pins.
	input  wire logic             int_irq,      // Internal interrupt request.
	output logic                  osc_run,      // Main oscillator running.
	output logic                  cpu_clk_en,   // CPU clock enable pulse.
	output logic                  periph_clk_en, // Peripheral clock enable.
	output logic                  sys_rst_n,    // System reset, active low.
	output logic                  int_disable,  // Interrupts disabled.
	output logic                  port_input_mode, // Ports forced to input.
	output logic                  pc_load,      // Program counter load pulse.
	output logic      [15:0]      pc_vector,    // Program counter load value.
	output logic                  fetch_en,     // Instruction fetch allowed.
	output logic                  wdt_enabled   // Watchdog armed.
);
	import ccr_pkg::*;

	if (FILT_LEN < 1 || FILT_LEN > 255) begin : g_chk
		$error("FILT_LEN must lie between 1 and 255");
	end

	// ------------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------------
	function automatic logic [3:0] div_limit(input ccr_div_t sel);
		case (sel)
			`CCR_DIV_16: div_limit = 4'hf;
			`CCR_DIV_8:  div_limit = 4'h7;
			`CCR_DIV_2:  div_limit = 4'h1;
			default:     div_limit = 4'h0;
		endcase
	endfunction

	function automatic logic bt_tick(input logic [1:0] sel, input logic [11:0] p);
		case (sel)
			2'b00:   bt_tick = &p;
			2'b01:   bt_tick = &p[9:0];
			2'b10:   bt_tick = &p[6:0];
			default: bt_tick = &p[3:0];
		endcase
	endfunction

	// ------------------------------------------------------------------------
	// Reset pin synchroniser and internal synchronous reset
	// ------------------------------------------------------------------------
	logic rst_meta_q;
	logic rst_sync_q;
	logic wdt_fire_q;
	logic srst;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= reset_pin_n;
			rst_sync_q <= rst_meta_q;
		end
	end

	assign srst = !rst_sync_q || wdt_fire_q;

	// ------------------------------------------------------------------------
	// AHB-Lite slave
	// ------------------------------------------------------------------------
	logic        ap_wr_q;
	logic [11:0] ap_addr_q;
	logic [31:0] hrdata_q;
	logic [31:0] rdata;
	logic        take;
	logic        wr_clk;
	logic        wr_bt;
	logic        wr_mode;

	logic [7:0]  clkctl_q;
	logic [7:0]  btctl_q;
	logic [7:0]  bt_cnt_q;
	logic [11:0] presc_q;
	ccr_state_t  st_q;

	assign take    = hsel && htrans[1] && hready;
	assign wr_clk  = ap_wr_q && ap_addr_q == `CCR_ADDR_CLKCTL;
	assign wr_bt   = ap_wr_q && ap_addr_q == `CCR_ADDR_BTCTL;
	assign wr_mode = ap_wr_q && ap_addr_q == `CCR_ADDR_MODE;

	always_comb begin
		case (haddr[11:0])
			`CCR_ADDR_CLKCTL: rdata = {24'h0, clkctl_q};
			`CCR_ADDR_BTCTL:  rdata = {24'h0, btctl_q};
			`CCR_ADDR_STATUS: rdata = {16'h0, bt_cnt_q, 5'h0, osc_run, st_q};
			default:          rdata = 32'h0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_q   <= 1'b0;
			ap_addr_q <= 12'h0;
			hrdata_q  <= 32'h0;
		end else begin
			ap_wr_q   <= take && hwrite;
			ap_addr_q <= haddr[11:0];
			hrdata_q  <= (take && !hwrite) ? rdata : 32'h0;
		end
	end

	assign hrdata    = hrdata_q;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ------------------------------------------------------------------------
	// Noise filter on the wake interrupt pins
	// ------------------------------------------------------------------------
	logic [7:0] filt_cnt_q;
	logic       wake_ext;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			filt_cnt_q <= 8'h0;
		end else if (!(|wake_interrupt_pins)) begin
			filt_cnt_q <= 8'h0;
		end else if (filt_cnt_q != 8'(FILT_LEN)) begin
			filt_cnt_q <= filt_cnt_q + 8'h1;
		end
	end

	assign wake_ext = filt_cnt_q == 8'(FILT_LEN);

	// ------------------------------------------------------------------------
	// Power state machine
	// ------------------------------------------------------------------------
	logic stop_req;
	logic wake_ok;
	logic stab_done;

	assign stop_req = (wr_clk && hwdata[`CCR_STOP_HI:`CCR_STOP_LO] == `CCR_STOP_CODE)
		|| (wr_mode && hwdata[`CCR_MODE_STOP_BIT]);
	assign wake_ok  = wake_ext && !clkctl_q[`CCR_WAKE_BIT];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= CCR_ST_STAB;
		end else if (srst) begin
			st_q <= CCR_ST_STAB;
		end else begin
			case (st_q)
				CCR_ST_STAB: begin
					if (stab_done) begin
						st_q <= CCR_ST_RUN;
					end
				end
				CCR_ST_RUN: begin
					if (stop_req) begin
						st_q <= CCR_ST_STOP;
					end else if (wr_mode && hwdata[`CCR_MODE_IDLE_BIT]) begin
						st_q <= CCR_ST_IDLE;
					end
				end
				CCR_ST_IDLE: begin
					if (int_irq || (|wake_interrupt_pins)) begin
						st_q <= CCR_ST_RUN;
					end
				end
				CCR_ST_STOP: begin
					if (wake_ok) begin
						st_q <= CCR_ST_STAB;
					end
				end
				default: st_q <= CCR_ST_STAB;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Clock control register
	// ------------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clkctl_q <= `CCR_CLKCTL_RST;
		end else if (srst) begin
			clkctl_q <= `CCR_CLKCTL_RST;
		end else if (wr_clk) begin
			clkctl_q[7:3] <= hwdata[7:3];
			if (hwdata[`CCR_SIG_HI:`CCR_SIG_LO] != `CCR_SIG_BAD) begin
				clkctl_q[`CCR_SIG_HI:`CCR_SIG_LO] <= hwdata[`CCR_SIG_HI:`CCR_SIG_LO];
			end
		end else if (st_q == CCR_ST_STOP && wake_ok) begin
			clkctl_q[`CCR_STOP_HI:`CCR_STOP_LO] <= `CCR_STOP_NONE;
		end
	end

	// ------------------------------------------------------------------------
	// Basic timer control, prescaler and counter
	// ------------------------------------------------------------------------
	logic tick;
	logic bt_ovf;
	logic wdt_on;

	assign tick   = bt_tick(btctl_q[`CCR_STAB_HI:`CCR_STAB_LO], presc_q);
	assign bt_ovf = tick && bt_cnt_q == 8'hff;
	assign wdt_on = btctl_q[`CCR_WDT_HI:`CCR_WDT_LO] != `CCR_WDT_OFF;
	assign stab_done = bt_ovf;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			btctl_q <= `CCR_BTCTL_RST;
		end else if (srst) begin
			btctl_q <= `CCR_BTCTL_RST;
		end else if (wr_bt) begin
			btctl_q <= {hwdata[7:2], 2'b00};
		end
	end

	// The prescaler and counter are held at zero while the oscillator is stopped.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			presc_q <= 12'h0;
		end else if (srst || st_q == CCR_ST_STOP) begin
			presc_q <= 12'h0;
		end else begin
			presc_q <= presc_q + 12'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bt_cnt_q <= 8'h0;
		end else if (srst || st_q == CCR_ST_STOP) begin
			bt_cnt_q <= 8'h0;
		end else if (wr_bt && hwdata[`CCR_BT_CLR_BIT]) begin
			bt_cnt_q <= 8'h0;
		end else if (tick) begin
			bt_cnt_q <= bt_cnt_q + 8'h1;
		end
	end

	// Overflow fires the watchdog only once the stabilisation wait is over.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdt_fire_q <= 1'b0;
		end else if (srst) begin
			wdt_fire_q <= 1'b0;
		end else begin
			wdt_fire_q <= bt_ovf && wdt_on
				&& (st_q == CCR_ST_RUN || st_q == CCR_ST_IDLE);
		end
	end

	// ------------------------------------------------------------------------
	// CPU clock divider
	// ------------------------------------------------------------------------
	logic [3:0] div_cnt_q;
	logic       cpu_en_q;
	logic [3:0] lim;

	assign lim = div_limit(clkctl_q[`CCR_DIV_HI:`CCR_DIV_LO]);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt_q <= 4'h0;
			cpu_en_q  <= 1'b0;
		end else if (srst || st_q != CCR_ST_RUN) begin
			div_cnt_q <= 4'h0;
			cpu_en_q  <= 1'b0;
		end else if (div_cnt_q >= lim) begin
			div_cnt_q <= 4'h0;
			cpu_en_q  <= 1'b1;
		end else begin
			div_cnt_q <= div_cnt_q + 4'h1;
			cpu_en_q  <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Reset sequence outputs
	// ------------------------------------------------------------------------
	logic srst_d1_q;
	logic pc_load_q;
	logic rst_out_q;
	logic fetch_q;
	logic osc_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			srst_d1_q <= 1'b1;
			pc_load_q <= 1'b0;
			rst_out_q <= 1'b0;
			fetch_q   <= 1'b0;
			osc_q     <= 1'b1;
		end else begin
			srst_d1_q <= srst;
			pc_load_q <= srst_d1_q && !srst;
			rst_out_q <= !srst;
			fetch_q   <= !srst && st_q == CCR_ST_RUN && !stop_req;
			osc_q     <= srst || st_q != CCR_ST_STOP;
		end
	end

	assign cpu_clk_en      = cpu_en_q;
	assign osc_run         = osc_q;
	assign periph_clk_en   = osc_q;
	assign sys_rst_n       = rst_out_q;
	assign int_disable     = !rst_out_q;
	assign port_input_mode = !rst_out_q;
	assign pc_load         = pc_load_q;
	assign pc_vector       = `CCR_RESET_VECTOR;
	assign fetch_en        = fetch_q;
	assign wdt_enabled     = wdt_on;

endmodule

// *** bench/ccr_osc_model.sv ***
// Model of the reset circuit and wake interrupt sources, clocked by the oscillator clock.
`timescale 1ns/1ps
module ccr_osc_model #(
	parameter int RST_HOLD = 100000,
	parameter int WAKE_LEN = 8
) (
	input  wire logic       clk,                 // Oscillator clock.
	input  wire logic       rst_req,             // Start a reset pulse.
	input  wire logic       wake_req,            // Start a wake pulse.
	input  wire logic [2:0] wsel,                // Pins to raise.
	output logic            reset_pin_n,         // Reset pin, active low.
	output logic [2:0]      wake_interrupt_pins  // Wake lines.
);
	int rst_cnt = RST_HOLD;
	int wake_cnt = 0;

	// The pin stays low for the whole hold after power-up and after each request.
	always @(posedge clk) begin
		rst_cnt <= rst_req ? RST_HOLD : (rst_cnt > 0 ? rst_cnt - 1 : 0);
		wake_cnt <= wake_req ? WAKE_LEN : (wake_cnt > 0 ? wake_cnt - 1 : 0);
	end
	assign reset_pin_n = (rst_cnt == 0);
	assign wake_interrupt_pins = (wake_cnt > 0) ? wsel : 3'b000;
endmodule

// *** bench/ccr_top_chk.sv ***
// Concurrent checks on the ports of the clock and reset control.
`timescale 1ns/1ps
module ccr_top_chk (
	input wire logic        hclk,                // Clock.
	input wire logic        hresetn,             // Reset, active low.
	input wire logic        reset_pin_n,         // Reset pin.
	input wire logic [2:0]  wake_interrupt_pins, // Wake lines.
	input wire logic        osc_run,             // Oscillator on.
	input wire logic        cpu_clk_en,          // CPU enable.
	input wire logic        periph_clk_en,       // Peripheral enable.
	input wire logic        sys_rst_n,           // System reset.
	input wire logic        int_disable,         // Interrupts off.
	input wire logic        port_input_mode,     // Ports input.
	input wire logic        pc_load,             // Vector load.
	input wire logic [15:0] pc_vector,           // Vector value.
	input wire logic        fetch_en             // Fetch allowed.
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_stop_no_fetch: assert property (!osc_run |-> !fetch_en && !cpu_clk_en)
		else $error("cpu active while oscillator stopped");
	a_periph_follows: assert property (periph_clk_en == osc_run)
		else $error("peripheral clock differs from oscillator");
	a_reset_int_off: assert property (!sys_rst_n |-> int_disable && port_input_mode)
		else $error("interrupts or ports not forced in reset");
	a_reset_no_run: assert property (!sys_rst_n |-> !fetch_en && !cpu_clk_en && !pc_load)
		else $error("cpu active during reset");
	a_pc_vector_load: assert property (pc_load |-> pc_vector == 16'h0100 && $rose(sys_rst_n))
		else $error("vector load wrong");
	a_fetch_waits: assert property (pc_load |-> !fetch_en [*8])
		else $error("fetch before stabilisation");
	a_osc_after_reset: assert property ($rose(sys_rst_n) |-> osc_run && pc_load)
		else $error("oscillator off after reset");
	a_pin_sync: assert property ($fell(reset_pin_n) && sys_rst_n |=> sys_rst_n ##[1:3] !sys_rst_n)
		else $error("reset pin not synchronised");
	a_stop_holds: assert property (!osc_run && wake_interrupt_pins == 3'b000 && reset_pin_n &&
		$past(wake_interrupt_pins) == 3'b000 |=> !osc_run || !sys_rst_n)
		else $error("oscillator woke without a source");
endmodule

bind ccr_top ccr_top_chk u_ccr_top_chk (.hclk, .hresetn, .reset_pin_n, .wake_interrupt_pins,
	.osc_run, .cpu_clk_en, .periph_clk_en, .sys_rst_n, .int_disable, .port_input_mode,
	.pc_load, .pc_vector, .fetch_en);

// *** bench/cpu_clock_and_reset_control_test.sv ***
// Self-checking bench of the clock and reset control.
`timescale 1ns/1ps
`include "ccr_consts.svh"
module cpu_clock_and_reset_control_test;
	logic        hclk, hreadyout, hresp, reset_pin_n, osc_run, cpu_clk_en, periph_clk_en;
	logic        sys_rst_n, int_disable, port_input_mode, pc_load, fetch_en, wdt_enabled;
	logic        hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, int_irq = 1'b0;
	logic        rst_req = 1'b0, wake_req = 1'b0, rd_dp = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rnd = 32'h8d70;
	logic [15:0] pc_vector;
	logic [2:0]  hsize = 3'b010, wsel = 3'b001, wake_interrupt_pins;
	logic [1:0]  htrans = 2'b00;
	wire         hready = hreadyout;
	logic [31:0] exp_q[$];
	int          err_count = 0, checks_done = 0, n;
	int          sh[4] = '{4, 3, 1, 0};

	ccr_top #(.FILT_LEN(2)) u_ccr_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .reset_pin_n, .wake_interrupt_pins,
		.int_irq, .osc_run, .cpu_clk_en, .periph_clk_en, .sys_rst_n, .int_disable,
		.port_input_mode, .pc_load, .pc_vector, .fetch_en, .wdt_enabled);
	ccr_osc_model #(.RST_HOLD(20), .WAKE_LEN(6)) u_ccr_osc_model (.clk(hclk), .rst_req,
		.wake_req, .wsel, .reset_pin_n, .wake_interrupt_pins);

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// One single word transfer; a read leaves its expected data in the queue.
	task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] d);
		@(posedge hclk);
		rnd = xs(rnd);
		haddr <= {rnd[31:12], a};
		hwrite <= wr;
		htrans <= 2'b10;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wr ? d : rnd;
		rd_dp <= !wr;
		if (!wr) exp_q.push_back(d);
		do @(posedge hclk); while (hready !== 1'b1);
		rd_dp <= 1'b0;
	endtask

	task automatic pulse_wake(input logic [2:0] p);
		wsel <= p;
		wake_req <= 1'b1;
		@(posedge hclk);
		wake_req <= 1'b0;
	endtask

	task automatic wait_fetch;
		n = 0;
		while (fetch_en !== 1'b1 && n < 9000) begin
			@(posedge hclk);
			n++;
		end
		check("fetch_en", fetch_en, 32'h1);
	endtask

	task automatic wait_rst(input logic v);
		n = 0;
		while (sys_rst_n !== v && n < 100) begin
			@(posedge hclk);
			n++;
		end
		check("sys_rst_n", sys_rst_n, v);
	endtask

	always @(posedge hclk) begin
		if (rd_dp === 1'b1 && hready === 1'b1) begin
			check("hrdata", hrdata, exp_q.pop_front());
			check("hresp", hresp, 32'h0);
		end
	end

	initial begin
		repeat (30000) @(posedge hclk);
		err_count++;
		print_verdict;
	end

	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		wait_rst(1'b1);
		check("pc_load", pc_load, 32'h1);
		check("pc_vector", pc_vector, 32'h0100);
		check("wdt_enabled", wdt_enabled, 32'h1);
		check("osc_run", osc_run, 32'h1);
		bus(`CCR_ADDR_CLKCTL, 1'b0, 32'h0);
		bus(`CCR_ADDR_BTCTL, 1'b1, 32'hac);
		@(posedge hclk);
		check("wdt_enabled", wdt_enabled, 32'h0);
		wait_fetch;
		bus(12'h0f0, 1'b1, rnd);
		bus(12'h0f0, 1'b0, 32'h0);
		for (int i = 0; i < 4; i++) begin
			bus(`CCR_ADDR_CLKCTL, 1'b1, 32'(((i == 2 ? 3 : i) << 5) | (i << 3)));
			repeat (16) @(posedge hclk);
			n = 0;
			repeat (32) begin
				@(posedge hclk);
				n += cpu_clk_en;
			end
			check("cpu_clk_en count", n, 32 >> sh[i]);
			check("osc_run", osc_run, 32'h1);
			bus(`CCR_ADDR_CLKCTL, 1'b0, 32'(((i == 2 ? 3 : i) << 5) | (i << 3)));
		end
		bus(`CCR_ADDR_CLKCTL, 1'b1, 32'h98);
		bus(`CCR_ADDR_CLKCTL, 1'b0, 32'h98);
		for (int j = 0; j < 2; j++) begin
			bus(`CCR_ADDR_MODE, 1'b1, 32'h1);
			repeat (4) @(posedge hclk);
			check("fetch_en idle", fetch_en, 32'h0);
			check("periph_clk_en", periph_clk_en, 32'h1);
			if (j == 0) int_irq <= 1'b1;
			else pulse_wake(3'b001);
			@(posedge hclk);
			int_irq <= 1'b0;
			wait_fetch;
		end
		bus(`CCR_ADDR_CLKCTL, 1'b1, 32'hd8);
		repeat (3) @(posedge hclk);
		check("osc_run stop", osc_run, 32'h0);
		pulse_wake(3'b100);
		repeat (20) @(posedge hclk);
		check("osc_run gated", osc_run, 32'h0);
		bus(`CCR_ADDR_CLKCTL, 1'b1, 32'h18);
		pulse_wake(3'b010);
		repeat (20) @(posedge hclk);
		check("osc_run woken", osc_run, 32'h1);
		bus(`CCR_ADDR_CLKCTL, 1'b0, 32'h18);
		bus(`CCR_ADDR_BTCTL, 1'b0, 32'hac);
		wait_fetch;
		bus(`CCR_ADDR_MODE, 1'b1, 32'h2);
		repeat (3) @(posedge hclk);
		check("osc_run mode stop", osc_run, 32'h0);
		rst_req <= 1'b1;
		@(posedge hclk);
		rst_req <= 1'b0;
		wait_rst(1'b0);
		check("int_disable", int_disable, 32'h1);
		check("port_input_mode", port_input_mode, 32'h1);
		wait_rst(1'b1);
		check("pc_load", pc_load, 32'h1);
		check("osc_run", osc_run, 32'h1);
		bus(`CCR_ADDR_CLKCTL, 1'b0, 32'h0);
		bus(`CCR_ADDR_BTCTL, 1'b0, 32'h0);
		bus(`CCR_ADDR_STATUS, 1'b0, 32'h4);
		check("wdt_enabled", wdt_enabled, 32'h1);
		bus(`CCR_ADDR_BTCTL, 1'b1, 32'h0c);
		wait_fetch;
		n = 0;
		while (sys_rst_n !== 1'b0 && n < 9000) begin
			@(posedge hclk);
			n++;
		end
		check("sys_rst_n watchdog", sys_rst_n, 32'h0);
		wait_rst(1'b1);
		check("pc_load", pc_load, 32'h1);
		bus(`CCR_ADDR_BTCTL, 1'b0, 32'h0);
		@(posedge hclk);
		print_verdict;
	end
endmodule
